// [hw/rtc_trim_output_power_stamp.sv]
// trimmed divider, multi-function open-drain pin and power-fail time stamps
// assumes osc_in and backup_in are pins; time, minute tick, alarm are on clk
module rtc_trim_output_power_stamp (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 osc_in,
  input  wire logic                 backup_in,
  input  wire rtc_trim_pkg::stamp_t current_time,
  input  wire logic                 minute_tick,
  input  wire logic                 alarm_level,
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_wdata,
  output logic [7:0]                reg_rd_data,
  output logic                      reg_ack,
  output logic                      mfp_out,
  output logic                      mfp_oe_n
);

  // ==========================================================================
  // pin synchronisers
  logic [2:0] osc_sync;
  logic [2:0] backup_sync;
  logic       osc_level;
  logic       osc_edge;
  logic       backup_level;
  logic       backup_prev;

  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_sync    <= 3'h0;
      backup_sync <= 3'h0;
    end else begin
      osc_sync    <= {osc_sync[1:0], osc_in};
      backup_sync <= {backup_sync[1:0], backup_in};
    end
  end

  // filtered levels and the oscillator rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_level    <= 1'b0;
      osc_edge     <= 1'b0;
      backup_level <= 1'b0;
      backup_prev  <= 1'b0;
    end else begin
      osc_edge    <= 1'b0;
      backup_prev <= backup_level;
      if (osc_sync[2] == osc_sync[1]) begin
        osc_level <= osc_sync[2];
        osc_edge  <= osc_sync[2] & ~osc_level;
      end
      if (backup_sync[2] == backup_sync[1]) begin
        backup_level <= backup_sync[2];
      end
    end
  end

  // ==========================================================================
  // registers
  rtc_trim_pkg::control_t control;
  rtc_trim_pkg::trim_t    trim;
  logic                   backup_flag;
  logic                   bus_ok;
  logic                   enter_backup;
  logic                   leave_backup;
  logic                   flag_clear;

  assign bus_ok       = ~backup_level;
  assign enter_backup = backup_level & ~backup_prev;
  assign leave_backup = ~backup_level & backup_prev;
  assign flag_clear   = reg_wr & bus_ok & (reg_addr == rtc_trim_pkg::ADDR_STATUS)
                        & ~reg_wdata[rtc_trim_pkg::BACKUP_FLAG_BIT] & backup_flag;

  // control and trim writes, ignored while on backup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= rtc_trim_pkg::CONTROL_RESET;
      trim    <= rtc_trim_pkg::TRIM_RESET;
    end else if (reg_wr && bus_ok) begin
      if (reg_addr == rtc_trim_pkg::ADDR_CONTROL) begin
        control <= reg_wdata;
      end else if (reg_addr == rtc_trim_pkg::ADDR_TRIM) begin
        trim <= reg_wdata;
      end
    end
  end

  // backup flag: the hardware set wins over a software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      backup_flag <= 1'b0;
    end else if (enter_backup) begin
      backup_flag <= 1'b1;
    end else if (flag_clear) begin
      backup_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // time stamps
  logic [7:0] stamp_rd;
  logic       stamp_sel;
  logic [7:0] reg_rd_q;

  stamp_store u_store (
    .clk      (clk),
    .rst_n    (rst_n),
    .cap_down (enter_backup),
    .cap_up   (leave_backup),
    .clear    (flag_clear),
    .now      (current_time),
    .rd_idx   (reg_addr[2:0]),
    .rd_data  (stamp_rd)
  );

  // register read decode, answered one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_q  <= 8'h00;
      stamp_sel <= 1'b0;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack   <= (reg_rd | reg_wr) & bus_ok;
      stamp_sel <= 1'b0;
      reg_rd_q  <= 8'h00;
      if (reg_rd && bus_ok) begin
        if (reg_addr == rtc_trim_pkg::ADDR_STATUS) begin
          reg_rd_q <= 8'(backup_flag) << rtc_trim_pkg::BACKUP_FLAG_BIT;
        end else if (reg_addr == rtc_trim_pkg::ADDR_CONTROL) begin
          reg_rd_q <= control;
        end else if (reg_addr == rtc_trim_pkg::ADDR_TRIM) begin
          reg_rd_q <= trim;
        end else if (reg_addr >= rtc_trim_pkg::ADDR_DOWN_STAMP
                     && reg_addr <= rtc_trim_pkg::ADDR_STAMP_LAST) begin
          stamp_sel <= 1'b1;
        end
      end
    end
  end

  assign reg_rd_data = stamp_sel ? stamp_rd : reg_rd_q;

  // ==========================================================================
  // trimmed divider

  // nominal period for a rate select value
  function automatic logic [15:0] base_period(input logic [2:0] rate);
    logic [15:0] p;
    p = rtc_trim_pkg::PERIOD_TEST;
    if (rate == rtc_trim_pkg::RATE_SLOW) begin
      p = rtc_trim_pkg::PERIOD_SLOW;
    end else if (rate == rtc_trim_pkg::RATE_MID) begin
      p = rtc_trim_pkg::PERIOD_MID;
    end else if (rate == rtc_trim_pkg::RATE_FAST) begin
      p = rtc_trim_pkg::PERIOD_FAST;
    end else if (rate == rtc_trim_pkg::RATE_FULL) begin
      p = rtc_trim_pkg::PERIOD_FULL;
    end
    return p;
  endfunction

  logic [2:0]  rate;
  logic        test_mode;
  logic [15:0] base;
  logic [15:0] adj;
  logic [15:0] next_period;
  logic [15:0] cur_period;
  logic [15:0] cnt;
  logic        minute_pending;
  logic        trim_now;
  logic        wrap;
  logic        ctrl_wr;

  assign rate      = {control.trim_test_select, control.rate_select_hi,
                      control.rate_select_lo};
  assign test_mode = control.trim_test_select;
  assign base      = base_period(rate);
  assign adj       = {8'h00, trim.magnitude, 1'b0};
  assign trim_now  = test_mode | minute_pending;
  assign wrap      = osc_edge & (cnt >= cur_period - rtc_trim_pkg::PERIOD_MIN);
  // an accepted control write, so a new rate never waits out the old period
  assign ctrl_wr   = reg_wr & bus_ok & (reg_addr == rtc_trim_pkg::ADDR_CONTROL);

  // period of the cycle about to start
  always_comb begin
    next_period = base;
    if (rate == rtc_trim_pkg::RATE_FULL || !trim_now) begin
      next_period = base;
    end else if (trim.subtract) begin
      // shortening saturates at one cycle
      next_period = (base > adj) ? base - adj : rtc_trim_pkg::PERIOD_MIN;
    end else begin
      next_period = base + adj;
    end
  end

  // one pending trim per minute; a new tick wins over consumption
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      minute_pending <= 1'b0;
    end else if (minute_tick) begin
      minute_pending <= 1'b1;
    end else if (wrap && !test_mode) begin
      minute_pending <= 1'b0;
    end
  end

  // input cycle counter within the output period; a control write restarts it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= 16'h0000;
      cur_period <= rtc_trim_pkg::PERIOD_SLOW;
    end else if (ctrl_wr) begin
      cnt        <= 16'h0000;
      cur_period <= base_period(reg_wdata[2:0]);
    end else if (wrap) begin
      cnt        <= 16'h0000;
      cur_period <= next_period;
    end else if (osc_edge) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // ==========================================================================
  // multi-function pin
  logic clk_wave;
  logic pin_level;
  logic pin_drive;

  // high for the nominal first half; trim lengthens or shortens the low part
  assign clk_wave = (rate == rtc_trim_pkg::RATE_FULL) ? osc_level
                    : (cnt < (base >> 1));

  // pin function select; on backup only the alarm may drive
  always_comb begin
    pin_level = control.output_level;
    pin_drive = 1'b1;
    if (backup_level) begin
      pin_drive = |control.alarm_enable;
      pin_level = alarm_level;
    end else if (control.square_wave_enable) begin
      pin_level = clk_wave;
    end else if (|control.alarm_enable) begin
      pin_level = alarm_level;
    end
  end

  // open drain: enable low pulls the pin low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mfp_oe_n <= 1'b1;
    end else begin
      mfp_oe_n <= ~(pin_drive & ~pin_level);
    end
  end

  assign mfp_out = 1'b0;

endmodule

// [hw/rtc_trim_pkg.sv]
// constants and carrier types for the trim, output pin and power stamp block
// assumes one 40 MHz clock and an internal byte-wide register port
package rtc_trim_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_STATUS     = 8'h03;
  localparam logic [7:0] ADDR_CONTROL    = 8'h07;
  localparam logic [7:0] ADDR_TRIM       = 8'h08;
  localparam logic [7:0] ADDR_DOWN_STAMP = 8'h18;
  localparam logic [7:0] ADDR_UP_STAMP   = 8'h1c;
  localparam logic [7:0] ADDR_STAMP_LAST = 8'h1f;

  // ==========================================================================
  // field positions and reset values
  localparam int         BACKUP_FLAG_BIT = 4;
  localparam logic [7:0] CONTROL_RESET   = 8'h80;
  localparam logic [7:0] TRIM_RESET      = 8'h00;
  localparam logic [7:0] STATUS_RESET    = 8'h00;

  // ==========================================================================
  // output periods in input clock cycles
  localparam logic [15:0] PERIOD_SLOW = 16'h8000;  // 32768 cycles
  localparam logic [15:0] PERIOD_MID  = 16'h0008;  // 8 cycles
  localparam logic [15:0] PERIOD_FAST = 16'h0004;  // 4 cycles
  localparam logic [15:0] PERIOD_FULL = 16'h0001;  // follows the oscillator
  localparam logic [15:0] PERIOD_TEST = 16'h0200;  // 512 cycles
  localparam logic [15:0] PERIOD_MIN  = 16'h0001;

  // ==========================================================================
  // rate select encodings
  localparam logic [2:0] RATE_SLOW = 3'h0;
  localparam logic [2:0] RATE_MID  = 3'h1;
  localparam logic [2:0] RATE_FAST = 3'h2;
  localparam logic [2:0] RATE_FULL = 3'h3;

  // control register layout
  typedef struct packed {
    logic       output_level;
    logic       square_wave_enable;
    logic [1:0] alarm_enable;
    logic       external_osc;
    logic       trim_test_select;
    logic       rate_select_hi;
    logic       rate_select_lo;
  } control_t;

  // trim register layout: sign then magnitude
  typedef struct packed {
    logic       subtract;
    logic [6:0] magnitude;
  } trim_t;

  // time as captured into a stamp set, one byte each
  typedef struct packed {
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] minute;
  } stamp_t;

endpackage

// [hw/stamp_store.sv]
// two power stamp sets of four bytes with a registered read port
// assumes capture and clear pulses from logic on the same clock
module stamp_store (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 cap_down,
  input  wire logic                 cap_up,
  input  wire logic                 clear,
  input  wire rtc_trim_pkg::stamp_t now,
  input  wire logic [2:0]           rd_idx,
  output logic [7:0]                rd_data
);

  // ==========================================================================
  // storage
  logic [7:0] mem [8];

  // capture wins over a clear in the same cycle, per set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cap_down) begin
          mem[i] <= now[i*8 +: 8];
        end else if (clear) begin
          mem[i] <= 8'h00;
        end
        if (cap_up) begin
          mem[i+4] <= now[i*8 +: 8];
        end else if (clear) begin
          mem[i+4] <= 8'h00;
        end
      end
    end
  end

  // registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end

endmodule

// [sim/rtc_trim_output_power_stamp_properties.sv]
// checker for the register port and pin of the trim and stamp block
// assumes only the top module ports, one clock, reset active low
module rtc_trim_output_power_stamp_properties (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       backup_in,
  input wire logic       alarm_level,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rd_data,
  input wire logic       reg_ack,
  input wire logic       mfp_out,
  input wire logic       mfp_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // clocking and sequences
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // main supply held past the synchroniser, then a request
  sequence s_main_req;
    (!backup_in) [*6] ##0 (reg_rd || reg_wr);
  endsequence
  // backup supply held past the synchroniser
  sequence s_backup;
    backup_in [*8];
  endsequence
  // ==========================================================================
  // register port and pin
  a_ack_on_main: assert property (s_main_req |=> reg_ack)
    else $error("request on main supply not acknowledged");
  a_no_ack_backup: assert property (s_backup |-> !reg_ack)
    else $error("ack given on backup supply");
  a_ack_needs_req: assert property (reg_ack |-> $past(reg_rd || reg_wr))
    else $error("ack without a request");
  a_data_after_rd: assert property (!$past(reg_rd) |-> reg_rd_data == 8'h00)
    else $error("read data without a read");
  a_data_with_ack: assert property (reg_rd_data != 8'h00 |-> reg_ack)
    else $error("read data without ack");
  a_open_drain: assert property (mfp_out == 1'b0)
    else $error("pin driven high");
  a_alarm_high_backup: assert property ((backup_in && alarm_level) [*8] |-> mfp_oe_n)
    else $error("pin pulled low on backup with alarm high");
  a_pin_frozen_backup: assert property
    ((backup_in && $stable(alarm_level)) [*8] |-> $stable(mfp_oe_n))
    else $error("pin toggles on backup without alarm change");
endmodule

bind rtc_trim_output_power_stamp rtc_trim_output_power_stamp_properties u_props (
  .clk(clk), .rst_n(rst_n), .backup_in(backup_in), .alarm_level(alarm_level),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .reg_ack(reg_ack),
  .mfp_out(mfp_out), .mfp_oe_n(mfp_oe_n)
);

// [sim/rtc_trim_output_power_stamp_tb_top.sv]
// bench for the trim, pin and stamp block through its byte register port
// assumes the oscillator model runs at eight clk periods a cycle
module rtc_trim_output_power_stamp_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          OSC_P = 8;  // clk periods per oscillator cycle
  localparam logic [31:0] T_DOWN = 32'h0312_2359;
  localparam logic [31:0] T_UP  = 32'h0313_0105;
  logic                 clk, rst_n, go_backup, osc_in, backup_in, minute_tick;
  logic                 alarm_level, reg_wr, reg_rd, reg_ack, mfp_out, mfp_oe_n;
  logic [7:0]           reg_addr, reg_wdata, reg_rd_data, q;
  rtc_trim_pkg::stamp_t current_time;
  int                   err_count, tests_run, a, b;
  // ==========================================================================
  // clock, partner and design
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  supply_osc_model model (.go_backup(go_backup), .osc_in(osc_in), .backup_in(backup_in));
  rtc_trim_output_power_stamp dut (
    .clk(clk), .rst_n(rst_n), .osc_in(osc_in), .backup_in(backup_in),
    .current_time(current_time), .minute_tick(minute_tick), .alarm_level(alarm_level),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rd_data(reg_rd_data), .reg_ack(reg_ack), .mfp_out(mfp_out), .mfp_oe_n(mfp_oe_n)
  );
  // ==========================================================================
  // tasks
  task stop_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // compare and count
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one strobe cycle, answer checked in the next, one idle cycle after
  task acc(input logic w, input logic [7:0] ad, input logic [7:0] d, input logic k);
    reg_wr = w;
    reg_rd = ~w;
    reg_addr = ad;
    reg_wdata = d;
    @(posedge clk);
    #1;
    q = reg_rd_data;
    chk("reg_ack", 16'(k), 16'(reg_ack));
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [7:0] ad, input logic [7:0] e);
    acc(1'b0, ad, 8'h00, 1'b1);
    chk("reg_rd_data", 16'(e), 16'(q));
  endtask
  // cycles until the pin reaches a level, bounded
  task wlv(input logic v, output int c);
    c = 0;
    while (mfp_oe_n !== v) begin
      @(posedge clk);
      #1;
      c++;
      if (c > 9000) begin
        chk("mfp_oe_n", 16'(v), 16'(mfp_oe_n));
        stop_test();
      end
    end
  endtask
  // one period measured from a rising edge of the pin
  task meas(input int e);
    wlv(1'b0, a);
    wlv(1'b1, b);
    chk("period", 16'(e), 16'(a + b));
  endtask
  task sync();
    wlv(1'b0, a);
    wlv(1'b1, a);
  endtask
  task tick();
    minute_tick = 1'b1;
    @(posedge clk);
    #1;
    minute_tick = 1'b0;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    go_backup = 1'b0;
    minute_tick = 1'b0;
    alarm_level = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_count = 0;
    tests_run = 0;
    current_time = T_DOWN;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(rtc_trim_pkg::ADDR_CONTROL, 8'h80);
    rd(rtc_trim_pkg::ADDR_TRIM, 8'h00);
    rd(rtc_trim_pkg::ADDR_STATUS, 8'h00);
    chk("static high", 16'h0001, 16'(mfp_oe_n));
    acc(1'b1, rtc_trim_pkg::ADDR_CONTROL, 8'h00, 1'b1);
    chk("static low", 16'h0000, 16'(mfp_oe_n));
    acc(1'b1, rtc_trim_pkg::ADDR_TRIM, 8'h05, 1'b1);
    rd(rtc_trim_pkg::ADDR_TRIM, 8'h05);
    acc(1'b1, rtc_trim_pkg::ADDR_CONTROL, 8'h41, 1'b1);
    sync();
    tick();
    sync();
    meas((8 + 10) * OSC_P);
    meas(8 * OSC_P);
    acc(1'b1, rtc_trim_pkg::ADDR_TRIM, 8'h81, 1'b1);
    sync();
    tick();
    sync();
    meas((8 - 2) * OSC_P);
    acc(1'b1, rtc_trim_pkg::ADDR_CONTROL, 8'h43, 1'b1);
    sync();
    tick();
    sync();
    meas(OSC_P);
    meas(OSC_P);
    acc(1'b1, rtc_trim_pkg::ADDR_TRIM, 8'h03, 1'b1);
    acc(1'b1, rtc_trim_pkg::ADDR_CONTROL, 8'h46, 1'b1);
    sync();
    meas((512 + 6) * OSC_P);
    meas((512 + 6) * OSC_P);
    acc(1'b1, rtc_trim_pkg::ADDR_TRIM, 8'h83, 1'b1);
    sync();
    meas((512 - 6) * OSC_P);
    acc(1'b1, rtc_trim_pkg::ADDR_CONTROL, 8'h51, 1'b1);
    go_backup = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("pin on backup", 16'h0001, 16'(mfp_oe_n));
    alarm_level = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("alarm on backup", 16'h0000, 16'(mfp_oe_n));
    alarm_level = 1'b1;
    acc(1'b0, rtc_trim_pkg::ADDR_STATUS, 8'h00, 1'b0);
    chk("refused data", 16'h0000, 16'(q));
    acc(1'b1, rtc_trim_pkg::ADDR_TRIM, 8'h7f, 1'b0);
    current_time = T_UP;
    go_backup = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    current_time = 32'h0101_0101;
    rd(rtc_trim_pkg::ADDR_STATUS, 8'h10);
    for (int i = 0; i < 4; i++) begin
      rd(rtc_trim_pkg::ADDR_DOWN_STAMP + 8'(i), T_DOWN[8*i+:8]);
      rd(rtc_trim_pkg::ADDR_UP_STAMP + 8'(i), T_UP[8*i+:8]);
    end
    acc(1'b1, rtc_trim_pkg::ADDR_STATUS, 8'h00, 1'b1);
    acc(1'b1, rtc_trim_pkg::ADDR_DOWN_STAMP, 8'haa, 1'b1);
    rd(rtc_trim_pkg::ADDR_STATUS, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd(rtc_trim_pkg::ADDR_DOWN_STAMP + 8'(i), 8'h00);
    end
    rd(8'h40, 8'h00);
    rd(rtc_trim_pkg::ADDR_TRIM, 8'h83);
    stop_test();
  end
endmodule

// [sim/supply_osc_model.sv]
// oscillator and supply monitor standing outside the block
// assumes the bench asks for backup supply by a plain level
module supply_osc_model (
  input  wire logic go_backup,
  output logic      osc_in,
  output logic      backup_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // free running oscillator, eight clk periods a cycle, unrelated phase
  initial begin
    osc_in = 1'b0;
    #7;
    forever #100 osc_in = ~osc_in;
  end
  // backup supply present whenever the main supply is down
  assign backup_in = go_backup;
endmodule
